// *** wmb_framer_regs.svh ***
// Constants for the Format B framer: layout codes, block sizes, CRC.
// Assumes inclusion by bare name from the framer module and the bench.
`ifndef WMB_FRAMER_REGS_SVH
`define WMB_FRAMER_REGS_SVH

// Layout and mode codes
`define WMB_LAYOUT_FMT_B     2'h1
`define WMB_EXT_MODE_SHORT   2'h1
`define WMB_EXT_MODE_LONG    2'h2
`define WMB_CI_EXT_SHORT     8'h8C
`define WMB_CI_EXT_LONG      8'h8D

// Block sizes in bytes, CRC bytes included where a block has them
`define WMB_BLK1_LEN         8'h0A
`define WMB_SEG2_PLAIN_MAX   8'h76
`define WMB_SEG_EXT_LONG_LEN 8'h09
`define WMB_SEG2_LONG_MAX    8'h6D
`define WMB_SEG_OPT_MAX      8'h80
`define WMB_CRC_LEN          8'h02

// CRC-16 generator and start value, result sent inverted, MSB first
`define WMB_CRC_POLY         16'h3D65
`define WMB_CRC_INIT         16'h0000

// Preamble, sync word and postamble limits
`define WMB_PRE_MIN_PAIRS    16'h0001
`define WMB_POST_MIN_BITS    4'h2
`define WMB_POST_MAX_BITS    4'h8
`define WMB_SYNC_MAX_BITS    6'h20

`endif

// *** wmb_pkg.sv ***
// Types shared by the Format B framer.
// Assumes no other package in the design.
package wmb_pkg;

    typedef enum logic [2:0] {
        WMB_TX_IDLE = 3'b000,
        WMB_TX_PRE  = 3'b001,
        WMB_TX_SYNC = 3'b010,
        WMB_TX_BODY = 3'b011,
        WMB_TX_POST = 3'b100
    } wmb_tx_state_t;

    typedef enum logic [1:0] {
        WMB_EXT_PLAIN = 2'b00,
        WMB_EXT_SHORT = 2'b01,
        WMB_EXT_LONG  = 2'b10
    } wmb_ext_layout_t;

endpackage

// *** wmb_format_b_framer.sv ***
// Format B frame builder (bit stream out) and frame parser (bytes in).
// Assumes a first-word-fall-through TX FIFO and an RX FIFO with room.
`timescale 1ns/1ps
`include "wmb_framer_regs.svh"

module wmb_format_b_framer
    import wmb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // Configuration levels
    input  wire logic [1:0]  packet_layout_select_i,
    input  wire logic [1:0]  tx_extension_layout_mode_i,
    input  wire logic        rx_extension_parse_disable_i,
    input  wire logic [15:0] tx_preamble_pairs_i,
    input  wire logic [15:0] tx_min_preamble_pairs_i,
    input  wire logic [31:0] tx_sync_word_i,
    input  wire logic [5:0]  tx_sync_len_i,
    input  wire logic [3:0]  tx_postamble_bits_i,
    // Transmit control
    input  wire logic        tx_start_i,
    output logic             tx_busy_o,
    output logic             tx_done_o,
    // TX FIFO read side
    input  wire logic [7:0]  tx_fifo_data_i,
    input  wire logic        tx_fifo_valid_i,
    output logic             tx_fifo_rd_o,
    // Bit stream to modulator
    output logic             tx_bit_o,
    output logic             tx_bit_valid_o,
    input  wire logic        tx_bit_ready_i,
    // Byte stream from demodulator
    input  wire logic        rx_frame_start_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_byte_valid_i,
    // RX FIFO write side
    output logic [7:0]       rx_fifo_data_o,
    output logic             rx_fifo_wr_o,
    // Receive status
    output logic             rx_busy_o,
    output logic             rx_done_o,
    output logic             rx_crc_err_o,
    output logic [1:0]       rx_ext_layout_o
);

    // Length of the block that starts now, capped by the bytes left
    function automatic logic [7:0] seg_first(input logic [7:0] rem,
                                             input logic       long_ext,
                                             input logic [1:0] idx);
        logic [7:0] cap;
        cap = `WMB_SEG_OPT_MAX;
        if (long_ext) begin
            if (idx == 2'h0) begin
                cap = `WMB_SEG_EXT_LONG_LEN;
            end else if (idx == 2'h1) begin
                cap = `WMB_SEG2_LONG_MAX;
            end
        end else if (idx == 2'h0) begin
            cap = `WMB_SEG2_PLAIN_MAX;
        end
        seg_first = (rem < cap) ? rem : cap;
    endfunction

    // Byte-wide CRC-16 step, MSB first
    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic [7:0]  data);
        logic [15:0] c;
        logic        fb;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ data[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ `WMB_CRC_POLY;
            end
        end
        crc_step = c;
    endfunction

    // Transmit state
    wmb_tx_state_t tx_state_ff;
    logic [16:0]   tx_cnt_ff;
    logic [2:0]    tx_bitcnt_ff;
    logic [7:0]    tx_sh_ff;
    logic          tx_last_ff;
    logic [7:0]    tx_hdr_ff;
    logic [7:0]    tx_rem_ff;
    logic [7:0]    tx_seg_ff;
    logic [1:0]    tx_idx_ff;
    logic [15:0]   tx_crc_ff;
    logic          tx_long_ff;
    logic          tx_bit_ff;
    logic          tx_bit_valid_ff;
    logic          tx_fifo_rd_ff;
    logic          tx_busy_ff;
    logic          tx_done_ff;

    // Transmit byte fetch decode
    logic          tx_adv;
    logic          tx_in_blk1;
    logic          tx_is_l;
    logic [7:0]    tx_eff_seg;
    logic          tx_crc_byte;
    logic [7:0]    tx_byte;
    logic          tx_load;
    logic [7:0]    nxt_tx_rem;
    logic [15:0]   nxt_pre_pairs;
    logic [5:0]    nxt_sync_len;
    logic [3:0]    nxt_post_len;

    assign tx_adv = !tx_bit_valid_ff || tx_bit_ready_i;

    always_comb begin
        tx_in_blk1  = (tx_hdr_ff != 8'h00);
        tx_is_l     = (tx_hdr_ff == `WMB_BLK1_LEN);
        tx_eff_seg  = (tx_seg_ff == 8'h00) ? seg_first(tx_rem_ff, tx_long_ff, tx_idx_ff)
                                           : tx_seg_ff;
        tx_crc_byte = !tx_in_blk1 && (tx_eff_seg <= `WMB_CRC_LEN);
        if (tx_crc_byte) begin
            tx_byte = (tx_eff_seg == `WMB_CRC_LEN) ? ~tx_crc_ff[15:8] : ~tx_crc_ff[7:0];
        end else begin
            tx_byte = tx_fifo_data_i;
        end
        tx_load = (tx_state_ff == WMB_TX_BODY) && tx_adv && (tx_bitcnt_ff == 3'h0) &&
                  !tx_last_ff && (tx_crc_byte || tx_fifo_valid_i);
        nxt_tx_rem = tx_is_l ? tx_byte : (tx_rem_ff - 8'h01);
        // Pair count raised to the tx_min_preamble_pairs_i minimum, never an empty preamble
        nxt_pre_pairs = (tx_preamble_pairs_i < tx_min_preamble_pairs_i) ?
                        tx_min_preamble_pairs_i : tx_preamble_pairs_i;
        if (nxt_pre_pairs < `WMB_PRE_MIN_PAIRS) begin
            nxt_pre_pairs = `WMB_PRE_MIN_PAIRS;
        end
        nxt_sync_len = (tx_sync_len_i > `WMB_SYNC_MAX_BITS) ? `WMB_SYNC_MAX_BITS
                                                             : tx_sync_len_i;
        // A one-bit postamble is not allowed, so it grows to two
        if (tx_postamble_bits_i == 4'h0) begin
            nxt_post_len = 4'h0;
        end else if (tx_postamble_bits_i < `WMB_POST_MIN_BITS) begin
            nxt_post_len = `WMB_POST_MIN_BITS;
        end else if (tx_postamble_bits_i > `WMB_POST_MAX_BITS) begin
            nxt_post_len = `WMB_POST_MAX_BITS;
        end else begin
            nxt_post_len = tx_postamble_bits_i;
        end
    end

    // Transmit sequencer and bit shifter
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_state_ff     <= WMB_TX_IDLE;
            tx_cnt_ff       <= 17'h00000;
            tx_bitcnt_ff    <= 3'h0;
            tx_sh_ff        <= 8'h00;
            tx_bit_ff       <= 1'b0;
            tx_bit_valid_ff <= 1'b0;
            tx_done_ff      <= 1'b0;
        end else begin
            tx_done_ff <= 1'b0;
            case (tx_state_ff)
                WMB_TX_IDLE: begin
                    tx_bit_valid_ff <= 1'b0;
                    if (tx_start_i && (packet_layout_select_i == `WMB_LAYOUT_FMT_B)) begin
                        tx_state_ff <= WMB_TX_PRE;
                        tx_cnt_ff   <= {nxt_pre_pairs, 1'b0};
                    end
                end
                WMB_TX_PRE: begin
                    if (tx_adv) begin
                        tx_bit_ff       <= tx_cnt_ff[0];
                        tx_bit_valid_ff <= 1'b1;
                        tx_cnt_ff       <= tx_cnt_ff - 17'h00001;
                        if (tx_cnt_ff == 17'h00001) begin
                            tx_state_ff  <= (nxt_sync_len == 6'h00) ? WMB_TX_BODY
                                                                    : WMB_TX_SYNC;
                            tx_cnt_ff    <= {11'h000, nxt_sync_len};
                            tx_bitcnt_ff <= 3'h0;
                        end
                    end
                end
                WMB_TX_SYNC: begin
                    if (tx_adv) begin
                        tx_bit_ff       <= tx_sync_word_i[tx_cnt_ff[4:0] - 5'h01];
                        tx_bit_valid_ff <= 1'b1;
                        tx_cnt_ff       <= tx_cnt_ff - 17'h00001;
                        if (tx_cnt_ff == 17'h00001) begin
                            tx_state_ff  <= WMB_TX_BODY;
                            tx_bitcnt_ff <= 3'h0;
                        end
                    end
                end
                WMB_TX_BODY: begin
                    if (tx_adv) begin
                        if (tx_bitcnt_ff != 3'h0) begin
                            tx_bit_ff       <= tx_sh_ff[7];
                            tx_bit_valid_ff <= 1'b1;
                            tx_sh_ff        <= {tx_sh_ff[6:0], 1'b0};
                            tx_bitcnt_ff    <= tx_bitcnt_ff - 3'h1;
                        end else if (tx_last_ff) begin
                            tx_bit_valid_ff <= 1'b0;
                            tx_state_ff     <= WMB_TX_POST;
                            tx_cnt_ff       <= {13'h0000, nxt_post_len};
                        end else if (tx_load) begin
                            tx_bit_ff       <= tx_byte[7];
                            tx_bit_valid_ff <= 1'b1;
                            tx_sh_ff        <= {tx_byte[6:0], 1'b0};
                            tx_bitcnt_ff    <= 3'h7;
                        end else begin
                            // FIFO ran dry: hold the line idle until data returns
                            tx_bit_valid_ff <= 1'b0;
                        end
                    end
                end
                WMB_TX_POST: begin
                    if (tx_adv) begin
                        if (tx_cnt_ff == 17'h00000) begin
                            tx_bit_valid_ff <= 1'b0;
                            tx_state_ff     <= WMB_TX_IDLE;
                            tx_done_ff      <= 1'b1;
                        end else begin
                            tx_bit_ff       <= tx_cnt_ff[0];
                            tx_bit_valid_ff <= 1'b1;
                            tx_cnt_ff       <= tx_cnt_ff - 17'h00001;
                        end
                    end
                end
                default: begin
                    tx_state_ff     <= WMB_TX_IDLE;
                    tx_bit_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    // Transmit block accounting and CRC insertion
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_hdr_ff     <= 8'h00;
            tx_rem_ff     <= 8'h00;
            tx_seg_ff     <= 8'h00;
            tx_idx_ff     <= 2'h0;
            tx_crc_ff     <= `WMB_CRC_INIT;
            tx_last_ff    <= 1'b0;
            tx_long_ff    <= 1'b0;
            tx_fifo_rd_ff <= 1'b0;
        end else begin
            tx_fifo_rd_ff <= tx_load && !tx_crc_byte;
            if (tx_state_ff == WMB_TX_IDLE) begin
                tx_hdr_ff  <= `WMB_BLK1_LEN;
                tx_rem_ff  <= 8'h00;
                tx_seg_ff  <= 8'h00;
                tx_idx_ff  <= 2'h0;
                tx_crc_ff  <= `WMB_CRC_INIT;
                tx_last_ff <= 1'b0;
                // Short extension shares the plain CRC placement
                tx_long_ff <= (tx_extension_layout_mode_i == `WMB_EXT_MODE_LONG);
            end else if (tx_load) begin
                tx_rem_ff  <= nxt_tx_rem;
                tx_last_ff <= (nxt_tx_rem == 8'h00);
                if (tx_in_blk1) begin
                    tx_hdr_ff <= tx_hdr_ff - 8'h01;
                end else begin
                    tx_seg_ff <= tx_eff_seg - 8'h01;
                    if ((tx_seg_ff == 8'h00) && (tx_idx_ff != 2'h2)) begin
                        tx_idx_ff <= tx_idx_ff + 2'h1;
                    end
                end
                if (!tx_crc_byte) begin
                    tx_crc_ff <= crc_step(tx_crc_ff, tx_byte);
                end else if (tx_eff_seg == 8'h01) begin
                    tx_crc_ff <= `WMB_CRC_INIT;
                end
            end
        end
    end

    // Transmit status
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_busy_ff <= 1'b0;
        end else begin
            tx_busy_ff <= (tx_state_ff != WMB_TX_IDLE);
        end
    end

    // Receive state
    logic          rx_busy_ff;
    logic [7:0]    rx_hdr_ff;
    logic [7:0]    rx_rem_ff;
    logic [7:0]    rx_seg_ff;
    logic [1:0]    rx_idx_ff;
    logic [15:0]   rx_crc_ff;
    logic          rx_long_ff;
    logic [1:0]    rx_ext_ff;
    logic [7:0]    rx_data_ff;
    logic          rx_wr_ff;
    logic          rx_done_ff;
    logic          rx_err_ff;

    // Receive byte decode
    logic          rx_take;
    logic          rx_in_blk1;
    logic          rx_is_l;
    logic          rx_ci_now;
    logic          rx_long_now;
    logic [7:0]    rx_eff_seg;
    logic          rx_crc_byte;
    logic [7:0]    rx_crc_exp;
    logic [7:0]    nxt_rx_rem;

    always_comb begin
        rx_take     = rx_busy_ff && rx_byte_valid_i;
        rx_in_blk1  = (rx_hdr_ff != 8'h00);
        rx_is_l     = (rx_hdr_ff == `WMB_BLK1_LEN);
        rx_ci_now   = !rx_in_blk1 && (rx_seg_ff == 8'h00) && (rx_idx_ff == 2'h0);
        rx_long_now = rx_ci_now ? (!rx_extension_parse_disable_i &&
                                   (rx_byte_i == `WMB_CI_EXT_LONG)) : rx_long_ff;
        rx_eff_seg  = (rx_seg_ff == 8'h00) ? seg_first(rx_rem_ff, rx_long_now, rx_idx_ff)
                                           : rx_seg_ff;
        rx_crc_byte = !rx_in_blk1 && (rx_eff_seg <= `WMB_CRC_LEN);
        rx_crc_exp  = (rx_eff_seg == `WMB_CRC_LEN) ? ~rx_crc_ff[15:8] : ~rx_crc_ff[7:0];
        nxt_rx_rem  = rx_is_l ? rx_byte_i : (rx_rem_ff - 8'h01);
    end

    // Receive parser, CRC check and strip
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_busy_ff <= 1'b0;
            rx_hdr_ff  <= 8'h00;
            rx_rem_ff  <= 8'h00;
            rx_seg_ff  <= 8'h00;
            rx_idx_ff  <= 2'h0;
            rx_crc_ff  <= `WMB_CRC_INIT;
            rx_long_ff <= 1'b0;
            rx_ext_ff  <= WMB_EXT_PLAIN;
            rx_data_ff <= 8'h00;
            rx_wr_ff   <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_err_ff  <= 1'b0;
        end else begin
            rx_wr_ff   <= 1'b0;
            rx_done_ff <= 1'b0;
            if (rx_frame_start_i && (packet_layout_select_i == `WMB_LAYOUT_FMT_B)) begin
                rx_busy_ff <= 1'b1;
                rx_hdr_ff  <= `WMB_BLK1_LEN;
                rx_rem_ff  <= 8'h00;
                rx_seg_ff  <= 8'h00;
                rx_idx_ff  <= 2'h0;
                rx_crc_ff  <= `WMB_CRC_INIT;
                rx_long_ff <= 1'b0;
                rx_ext_ff  <= WMB_EXT_PLAIN;
                rx_err_ff  <= 1'b0;
            end else if (rx_take) begin
                rx_rem_ff <= nxt_rx_rem;
                if (nxt_rx_rem == 8'h00) begin
                    rx_busy_ff <= 1'b0;
                    rx_done_ff <= 1'b1;
                end
                if (rx_in_blk1) begin
                    rx_hdr_ff <= rx_hdr_ff - 8'h01;
                end else begin
                    rx_seg_ff <= rx_eff_seg - 8'h01;
                    if ((rx_seg_ff == 8'h00) && (rx_idx_ff != 2'h2)) begin
                        rx_idx_ff <= rx_idx_ff + 2'h1;
                    end
                end
                if (rx_ci_now && !rx_extension_parse_disable_i) begin
                    rx_long_ff <= rx_long_now;
                    if (rx_byte_i == `WMB_CI_EXT_SHORT) begin
                        rx_ext_ff <= WMB_EXT_SHORT;
                    end else if (rx_byte_i == `WMB_CI_EXT_LONG) begin
                        rx_ext_ff <= WMB_EXT_LONG;
                    end
                end
                if (rx_crc_byte) begin
                    // CRC bytes are checked here and never reach the FIFO
                    if (rx_byte_i != rx_crc_exp) begin
                        rx_err_ff <= 1'b1;
                    end
                    if (rx_eff_seg == 8'h01) begin
                        rx_crc_ff <= `WMB_CRC_INIT;
                    end
                end else begin
                    rx_crc_ff  <= crc_step(rx_crc_ff, rx_byte_i);
                    rx_data_ff <= rx_byte_i;
                    rx_wr_ff   <= 1'b1;
                end
            end
        end
    end

    // Outputs straight from flops
    assign tx_busy_o       = tx_busy_ff;
    assign tx_done_o       = tx_done_ff;
    assign tx_fifo_rd_o    = tx_fifo_rd_ff;
    assign tx_bit_o        = tx_bit_ff;
    assign tx_bit_valid_o  = tx_bit_valid_ff;
    assign rx_fifo_data_o  = rx_data_ff;
    assign rx_fifo_wr_o    = rx_wr_ff;
    assign rx_busy_o       = rx_busy_ff;
    assign rx_done_o       = rx_done_ff;
    assign rx_crc_err_o    = rx_err_ff;
    assign rx_ext_layout_o = rx_ext_ff;

endmodule

// *** wmb_framer_assertions.sv ***
// Concurrent checks on the Format B framer's ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module wmb_framer_checker (
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    // Transmit side
    input wire logic [1:0] packet_layout_select_i,
    input wire logic       tx_start_i,
    input wire logic       tx_busy_o,
    input wire logic       tx_done_o,
    input wire logic       tx_fifo_rd_o,
    input wire logic       tx_bit_o,
    input wire logic       tx_bit_valid_o,
    input wire logic       tx_bit_ready_i,
    // Receive side
    input wire logic       rx_frame_start_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic       rx_byte_valid_i,
    input wire logic [7:0] rx_fifo_data_o,
    input wire logic       rx_fifo_wr_o,
    input wire logic       rx_busy_o,
    input wire logic       rx_done_o,
    input wire logic       rx_crc_err_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_tx_take: assert property ($rose(tx_busy_o) |-> $past(tx_start_i, 2)
        && $past(packet_layout_select_i, 2) == 2'h1) else $error("tx began without start");
    a_pre_first: assert property ($rose(tx_busy_o) |->
        tx_bit_valid_o && !tx_bit_o) else $error("preamble does not open with 0");
    a_bit_hold: assert property (tx_bit_valid_o && !tx_bit_ready_i |=>
        tx_bit_valid_o && $stable(tx_bit_o)) else $error("bit changed while stalled");
    a_done_pulse: assert property (tx_done_o |=> !tx_done_o && !tx_bit_valid_o)
        else $error("tx done not a single pulse");
    a_pop_pulse: assert property (tx_fifo_rd_o |=> !tx_fifo_rd_o)
        else $error("fifo pop longer than one cycle");
    a_rx_take: assert property ($rose(rx_busy_o) |-> $past(rx_frame_start_i)
        && $past(packet_layout_select_i) == 2'h1) else $error("rx began without start");
    a_wr_cause: assert property (rx_fifo_wr_o |-> $past(rx_byte_valid_i)
        && rx_fifo_data_o == $past(rx_byte_i)) else $error("rx write without byte");
    a_err_hold: assert property (rx_crc_err_o && !rx_frame_start_i |=>
        rx_crc_err_o) else $error("crc error dropped early");
    a_rx_done: assert property (rx_done_o |=> !rx_done_o)
        else $error("rx done not a single pulse");
endmodule

bind wmb_format_b_framer wmb_framer_checker u_chk (
    .clk_sys_i, .nrst_i, .packet_layout_select_i, .tx_start_i, .tx_busy_o, .tx_done_o,
    .tx_fifo_rd_o, .tx_bit_o, .tx_bit_valid_o, .tx_bit_ready_i, .rx_frame_start_i,
    .rx_byte_i, .rx_byte_valid_i, .rx_fifo_data_o, .rx_fifo_wr_o, .rx_busy_o,
    .rx_done_o, .rx_crc_err_o
);

// *** wmb_remote_node.sv ***
// Remote node model: sinks the framer's bit stream and logs every bit.
// Assumes the bench reads the log through the instance path.
`timescale 1ns/1ps
module wmb_remote_node (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    // Bit stream from the framer
    input  wire logic bit_i,
    input  wire logic bit_valid_i,
    input  wire logic slow_i,
    output logic      ready_o
);
    logic ready_ff;
    logic bits [$];

    // Slow mode stalls every other cycle so the hold is exercised
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= slow_i ? !ready_ff : 1'b1;
        end
    end
    assign ready_o = ready_ff;

    always @(posedge clk_sys_i) begin
        if (nrst_i && bit_valid_i && ready_ff) begin
            bits.push_back(bit_i);
        end
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the Format B framer: transmit stream and receive parse.
// Assumes the remote node model and the checker bind are compiled first.
`timescale 1ns/1ps
`include "wmb_framer_regs.svh"
module tb;
    import wmb_pkg::*;
    logic       clk_sys_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic [1:0] sel = 2'h1;
    logic [1:0] mode = 2'h0;
    logic       dis = 1'b0;
    logic       tx_start = 1'b0;
    logic       slow = 1'b0;
    logic       rx_start = 1'b0;
    logic       rx_vld = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [7:0] rp = 8'h00;
    logic [7:0] wp = 8'h00;
    logic [7:0] mem [256];
    logic [7:0] fr [$];
    logic [7:0] rxq [$];
    bit         isc [$];
    logic       tx_busy, tx_done, rd, tbit, tvld, trdy, wr, rx_busy, rx_done, err;
    logic [7:0] rx_data;
    logic [1:0] ext;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cyc = 0;

    wmb_format_b_framer u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .packet_layout_select_i(sel), .tx_extension_layout_mode_i(mode),
        .rx_extension_parse_disable_i(dis), .tx_preamble_pairs_i(16'h0002),
        .tx_min_preamble_pairs_i(16'h0003), .tx_sync_word_i(32'h000000A5),
        .tx_sync_len_i(6'h08), .tx_postamble_bits_i(4'h2), .tx_start_i(tx_start),
        .tx_busy_o(tx_busy), .tx_done_o(tx_done), .tx_fifo_data_i(mem[rp]),
        .tx_fifo_valid_i(rp != wp), .tx_fifo_rd_o(rd), .tx_bit_o(tbit),
        .tx_bit_valid_o(tvld), .tx_bit_ready_i(trdy), .rx_frame_start_i(rx_start),
        .rx_byte_i(rx_byte), .rx_byte_valid_i(rx_vld), .rx_fifo_data_o(rx_data),
        .rx_fifo_wr_o(wr), .rx_busy_o(rx_busy), .rx_done_o(rx_done),
        .rx_crc_err_o(err), .rx_ext_layout_o(ext));
    wmb_remote_node u_node (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bit_i(tbit),
        .bit_valid_i(tvld), .slow_i(slow), .ready_o(trdy));

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (rd) rp <= rp + 8'h01;
        if (wr) rxq.push_back(rx_data);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic add(input logic [7:0] b, input bit c);
        fr.push_back(b);
        isc.push_back(c);
    endtask
    // CRC of bytes from index a to the current end, sent inverted
    task automatic add_crc(input int a);
        logic [15:0] c;
        c = `WMB_CRC_INIT;
        for (int i = a; i < fr.size(); i++)
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[i][k]) ? `WMB_CRC_POLY : 16'h0000);
        add(~c[15:8], 1'b1);
        add(~c[7:0], 1'b1);
    endtask
    task automatic build(input logic [7:0] ci, input bit lng);
        int s;
        fr = {};
        isc = {};
        s = 0;
        add(lng ? 8'h17 : 8'h0E, 1'b0);
        for (int i = 1; i < 10; i++) add(8'h10 + 8'(i), 1'b0);
        add(ci, 1'b0);
        if (lng) begin
            for (int i = 0; i < 6; i++) add(8'h20 + 8'(i), 1'b0);
            add_crc(0);
            s = fr.size();
            add(8'h7A, 1'b0);
        end
        add(8'h55, 1'b0);
        add(8'hC3, 1'b0);
        add_crc(s);
    endtask

    task automatic ignore_case();
        @(posedge clk_sys_i);
        sel <= 2'h0;
        tx_start <= 1'b1;
        rx_start <= 1'b1;
        @(posedge clk_sys_i);
        tx_start <= 1'b0;
        rx_start <= 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk({tx_busy, rx_busy, tvld}, 3'b000);
        @(posedge clk_sys_i);
        sel <= 2'h1;
        $display("ignore test done");
    endtask
    task automatic tx_case(input logic [1:0] m, input logic [7:0] ci, input bit lng,
                           input bit sl);
        int n0;
        int k;
        build(ci, lng);
        k = 0;
        foreach (fr[i]) if (!isc[i]) begin
            mem[wp + 8'(k)] = fr[i];
            k++;
        end
        n0 = u_node.bits.size();
        @(posedge clk_sys_i);
        mode <= m;
        slow <= sl;
        tx_start <= 1'b1;
        wp <= wp + 8'(k);
        @(posedge clk_sys_i);
        tx_start <= 1'b0;
        k = 0;
        while (!tx_done && k < 5000) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk(k < 5000, 1);
        chk(u_node.bits.size() - n0, 16 + 8 * fr.size());
        for (int i = 0; i < 6; i++) chk(u_node.bits[n0 + i], i % 2);
        for (int i = 0; i < 8; i++)
            chk(u_node.bits[n0 + 6 + i], 8'hA5 >> (7 - i) & 1);
        foreach (fr[i]) for (int b = 0; b < 8; b++)
            chk(u_node.bits[n0 + 14 + 8 * i + b], fr[i][7 - b]);
        $display("tx test mode %0d done", m);
    endtask
    task automatic rx_case(input logic [7:0] ci, input bit lng, input bit d, input bit bad,
                           input logic [1:0] lay);
        int k;
        build(ci, lng);
        if (bad) fr[fr.size() - 1] ^= 8'h01;
        rxq = {};
        @(posedge clk_sys_i);
        dis <= d;
        rx_start <= 1'b1;
        foreach (fr[i]) begin
            @(posedge clk_sys_i);
            rx_start <= 1'b0;
            rx_byte <= fr[i];
            rx_vld <= 1'b1;
        end
        @(posedge clk_sys_i);
        rx_vld <= 1'b0;
        k = 0;
        while (!rx_done && k < 50) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk(k < 50, 1);
        k = 0;
        foreach (fr[i]) if (!isc[i]) begin
            chk(rxq[k], fr[i]);
            k++;
        end
        chk(rxq.size(), k);
        chk(err, bad);
        chk(ext, lay);
        $display("rx test ci %h done", ci);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        ignore_case();
        tx_case(2'h0, 8'h7A, 1'b0, 1'b0);
        tx_case(2'h1, 8'h8C, 1'b0, 1'b1);
        tx_case(2'h2, 8'h8D, 1'b1, 1'b1);
        rx_case(8'h7A, 1'b0, 1'b0, 1'b0, 2'h0);
        rx_case(8'h7A, 1'b0, 1'b0, 1'b1, 2'h0);
        rx_case(8'h8C, 1'b0, 1'b0, 1'b0, 2'h1);
        rx_case(8'h8D, 1'b1, 1'b0, 1'b0, 2'h2);
        rx_case(8'h8D, 1'b0, 1'b1, 1'b0, 2'h0);
        summarize();
    end
endmodule
